// ===== logic/cis_pkg.sv
/*
 cis_pkg: constants and state type for the interrupt entry/exit sequencer.
 assumes a byte-wide stack memory and a 15-bit word-addressed program counter.
*/
`default_nettype none
package cis_pkg;
   localparam int NUM_SRC_DEF       = 8;
   localparam int PC_W              = 15;
   localparam int SP_W              = 16;
   localparam int BYTE_W            = 8;
   localparam int CNT_W             = 16;
   localparam int ENTRY_CYC         = 4;
   localparam int RETURN_CYC        = 4;
   localparam int JUMP_CYC          = 3;
   localparam int WAKE_EXTRA_CYC    = 4;
   localparam int SLEEP_STARTUP_DEF = 6;
   // each vector slot holds a two-word jump
   localparam int VEC_STRIDE        = 2;
   localparam logic [SP_W-1:0]  SP_STEP        = 16'h0002;
   localparam logic [SP_W-1:0]  SP_ONE         = 16'h0001;
   localparam logic [SP_W-1:0]  SP_RESET       = 16'h0000;
   localparam logic [PC_W-1:0]  APP_BASE       = 15'h0000;
   localparam logic [PC_W-1:0]  BOOT_START_DEF = 15'h7000;
   localparam logic [CNT_W-1:0] PUSH_LO_CNT    = 16'h0000;
   localparam logic [CNT_W-1:0] PUSH_HI_CNT    = 16'h0001;
   localparam logic [CNT_W-1:0] POP_HI_CNT     = 16'h0002;
   localparam int PC_LO_W = BYTE_W;
   localparam int PC_HI_W = PC_W - BYTE_W;
   typedef enum logic [2:0] {
      CIS_IDLE,
      CIS_WAKE,
      CIS_ENTRY,
      CIS_JUMP,
      CIS_RETURN
   } cis_state_t;
endpackage : cis_pkg
`default_nettype wire

// ===== logic/cis_sequencer.sv
/*
 cis_sequencer: interrupt arbitration, entry push and return pop for a small core.
 assumes the core flags instruction boundaries, obeys core_stall_o and that the
 stack memory answers a read one cycle after stack_re_o.
*/
// Functional notes
// - one undivided cpu clock drives all sequencer logic
// - reset and every source get their own vector address
// - take a request only with its enable and global enable set
// - boot lock bits suppress interrupts depending on program counter region
// - vectors at lowest addresses; lower address means higher priority
// - vector relocate bit moves vectors to boot section start
// - reset relocate fuse moves reset vector to boot section start
// - accepting an interrupt clears global enable
// - global enable set inside a handler allows nesting
// - hardware clears a flag source's pending flag on vectoring
// - writing one clears a flag, writing zero leaves it
// - flag events held while disabled until enabled or cleared
// - pending flags served in priority order once global enable set
// - level sources request only while their condition is present
// - one main instruction runs after return before next interrupt
// - status word not saved or restored by hardware
// - global disable takes effect at once, same-cycle requests too
// - instruction after global enable runs before pending interrupts
// - entry takes four cycles, pushing program counter
// - vector jump takes three cycles to reach the handler
// - interrupts wait for multi-cycle instructions to complete
// - wake from sleep adds four cycles beyond start-up time
// - return takes four cycles, pops pc, sp plus two, sets enable
// - entry decrements stack pointer by two
`timescale 1ns/100ps
`default_nettype none
module cis_sequencer
   import cis_pkg::*;
#(
   parameter int                 NUM_SRC           = NUM_SRC_DEF,
   parameter logic [NUM_SRC-1:0] LEVEL_MASK        = '0,
   parameter logic [PC_W-1:0]    BOOT_START        = BOOT_START_DEF,
   parameter int                 SLEEP_STARTUP_CYC = SLEEP_STARTUP_DEF
)(
   input  wire logic               sys_clk_i,
   input  wire logic               rst_i,
   input  wire logic               instr_done_i,
   input  wire logic               cli_i,
   input  wire logic               sei_i,
   input  wire logic               return_from_irq_i,
   input  wire logic               sleeping_i,
   input  wire logic               status_gie_wr_i,
   input  wire logic               status_gie_data_i,
   input  wire logic [NUM_SRC-1:0] flag_event_i,
   input  wire logic [NUM_SRC-1:0] level_req_i,
   input  wire logic [NUM_SRC-1:0] irq_enable_i,
   input  wire logic               flag_clear_wr_i,
   input  wire logic [NUM_SRC-1:0] flag_clear_data_i,
   input  wire logic               vector_relocate_i,
   input  wire logic               reset_vector_relocate_fuse_i,
   input  wire logic               app_boot_lock_bit_i,
   input  wire logic               boot_section_lock_bit_i,
   input  wire logic [PC_W-1:0]    pc_i,
   input  wire logic               sp_wr_i,
   input  wire logic [SP_W-1:0]    sp_wr_data_i,
   input  wire logic [BYTE_W-1:0]  stack_rdata_i,
   output logic                    gie_o,
   output logic [NUM_SRC-1:0]      flags_o,
   output logic [NUM_SRC-1:0]      ack_o,
   output logic                    core_stall_o,
   output logic                    wake_o,
   output logic                    pc_load_o,
   output logic [PC_W-1:0]         pc_load_addr_o,
   output logic                    stack_we_o,
   output logic                    stack_re_o,
   output logic [SP_W-1:0]         stack_addr_o,
   output logic [BYTE_W-1:0]       stack_wdata_o,
   output logic [SP_W-1:0]         sp_o
);
   localparam int IDX_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

   function automatic logic [IDX_W-1:0] prio_idx(input logic [NUM_SRC-1:0] req);
      logic [IDX_W-1:0] idx;
      idx = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = IDX_W'(i);
         end
      end
      return idx;
   endfunction : prio_idx

   // slot 0 belongs to reset, source n sits at slot n+1
   function automatic logic [PC_W-1:0] vec_of(input logic [PC_W-1:0] base,
                                              input logic [IDX_W-1:0] idx);
      return base + PC_W'((int'(idx) + 1) * VEC_STRIDE);
   endfunction : vec_of

   cis_state_t         state_reg, state_next;
   logic [CNT_W-1:0]   cnt_reg, cnt_next;
   logic               gie_reg, gie_next;
   logic [NUM_SRC-1:0] flag_reg, flag_next;
   logic [NUM_SRC-1:0] ack_reg, ack_next;
   logic [IDX_W-1:0]   sel_reg, sel_next;
   logic [PC_W-1:0]    ret_pc_reg, ret_pc_next;
   logic [PC_HI_W-1:0] pop_hi_reg, pop_hi_next;
   logic [SP_W-1:0]    sp_reg, sp_next;
   logic               boot_reg, boot_next;
   logic               stall_reg, stall_next;
   logic               wake_reg, wake_next;
   logic               load_reg, load_next;
   logic [PC_W-1:0]    load_addr_reg, load_addr_next;
   logic               we_reg, we_next;
   logic               re_reg, re_next;
   logic [SP_W-1:0]    addr_reg, addr_next;
   logic [BYTE_W-1:0]  wdata_reg, wdata_next;

   logic [NUM_SRC-1:0] pending;
   logic [NUM_SRC-1:0] eligible;
   logic [NUM_SRC-1:0] clr_mask;
   logic [IDX_W-1:0]   sel_now;
   logic [PC_W-1:0]    vec_base;
   logic               lock_block;
   logic               take_ok;
   logic               do_take;

   always_comb begin
      pending  = (flag_reg & ~LEVEL_MASK) | (level_req_i & LEVEL_MASK);
      eligible = pending & irq_enable_i;
      sel_now  = prio_idx(eligible);
      vec_base = vector_relocate_i ? BOOT_START : APP_BASE;
      // vectors in the other section are blocked while running from the locked one
      lock_block = (app_boot_lock_bit_i && vector_relocate_i && (pc_i < BOOT_START)) ||
                   (boot_section_lock_bit_i && !vector_relocate_i && (pc_i >= BOOT_START));
      // gie_reg only rises after the enabling instruction retires, so the next one runs first
      take_ok  = gie_reg && !cli_i && !lock_block && (|eligible);
      do_take  = 1'b0;
      state_next     = state_reg;
      cnt_next       = cnt_reg + 1'b1;
      gie_next       = gie_reg;
      ack_next       = '0;
      sel_next       = sel_reg;
      ret_pc_next    = ret_pc_reg;
      pop_hi_next    = pop_hi_reg;
      sp_next        = sp_wr_i ? sp_wr_data_i : sp_reg;
      boot_next      = 1'b0;
      wake_next      = 1'b0;
      load_next      = 1'b0;
      load_addr_next = load_addr_reg;
      we_next        = 1'b0;
      re_next        = 1'b0;
      addr_next      = addr_reg;
      wdata_next     = wdata_reg;
      if (status_gie_wr_i) begin
         gie_next = status_gie_data_i;
      end
      if (sei_i) begin
         gie_next = 1'b1;
      end
      if (cli_i) begin
         gie_next = 1'b0;
      end
      case (state_reg)
         CIS_IDLE: begin
            if (boot_reg) begin
               load_next      = 1'b1;
               load_addr_next = reset_vector_relocate_fuse_i ? BOOT_START : APP_BASE;
            end else if (return_from_irq_i) begin
               state_next = CIS_RETURN;
               cnt_next   = '0;
            end else if (take_ok && sleeping_i) begin
               state_next = CIS_WAKE;
               wake_next  = 1'b1;
               cnt_next   = '0;
            end else if (take_ok && instr_done_i) begin
               do_take = 1'b1;
            end
         end
         CIS_WAKE: begin
            if (cnt_reg == CNT_W'(SLEEP_STARTUP_CYC + WAKE_EXTRA_CYC - 1)) begin
               if (take_ok) begin
                  do_take = 1'b1;
               end else begin
                  state_next = CIS_IDLE;
               end
            end
         end
         CIS_ENTRY: begin
            if (cnt_reg == PUSH_LO_CNT) begin
               we_next    = 1'b1;
               addr_next  = sp_reg;
               wdata_next = ret_pc_reg[PC_LO_W-1:0];
            end
            if (cnt_reg == PUSH_HI_CNT) begin
               we_next    = 1'b1;
               addr_next  = sp_reg - SP_ONE;
               wdata_next = {1'b0, ret_pc_reg[PC_W-1:PC_LO_W]};
               sp_next    = sp_reg - SP_STEP;
            end
            if (cnt_reg == CNT_W'(ENTRY_CYC - 1)) begin
               load_next      = 1'b1;
               load_addr_next = vec_of(vec_base, sel_reg);
               state_next     = CIS_JUMP;
               cnt_next       = '0;
            end
         end
         CIS_JUMP: begin
            // the core runs the vector jump; no arbitration until it lands
            if (cnt_reg == CNT_W'(JUMP_CYC - 1)) begin
               state_next = CIS_IDLE;
            end
         end
         CIS_RETURN: begin
            if (cnt_reg == PUSH_LO_CNT) begin
               re_next   = 1'b1;
               addr_next = sp_reg + SP_ONE;
            end
            if (cnt_reg == PUSH_HI_CNT) begin
               re_next   = 1'b1;
               addr_next = sp_reg + SP_STEP;
               sp_next   = sp_reg + SP_STEP;
            end
            if (cnt_reg == POP_HI_CNT) begin
               pop_hi_next = stack_rdata_i[PC_HI_W-1:0];
            end
            if (cnt_reg == CNT_W'(RETURN_CYC - 1)) begin
               load_next      = 1'b1;
               load_addr_next = {pop_hi_reg, stack_rdata_i};
               gie_next       = 1'b1;
               state_next     = CIS_IDLE;
            end
         end
         default: begin
            state_next = CIS_IDLE;
         end
      endcase
      if (do_take) begin
         // only the enable bit of the status word is touched here
         gie_next    = 1'b0;
         sel_next    = sel_now;
         ret_pc_next = pc_i;
         ack_next    = NUM_SRC'(1) << sel_now;
         state_next  = CIS_ENTRY;
         cnt_next    = '0;
      end
      clr_mask  = (flag_clear_wr_i ? flag_clear_data_i : '0) | (ack_next & ~LEVEL_MASK);
      // an event in the clearing cycle survives
      flag_next = (flag_reg & ~clr_mask) | (flag_event_i & ~LEVEL_MASK);
      stall_next = (state_next == CIS_WAKE) || (state_next == CIS_ENTRY) ||
                   (state_next == CIS_RETURN);
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_reg     <= CIS_IDLE;
         cnt_reg       <= '0;
         gie_reg       <= 1'b0;
         flag_reg      <= '0;
         ack_reg       <= '0;
         sel_reg       <= '0;
         ret_pc_reg    <= APP_BASE;
         pop_hi_reg    <= '0;
         sp_reg        <= SP_RESET;
         boot_reg      <= 1'b1;
         stall_reg     <= 1'b0;
         wake_reg      <= 1'b0;
         load_reg      <= 1'b0;
         load_addr_reg <= APP_BASE;
         we_reg        <= 1'b0;
         re_reg        <= 1'b0;
         addr_reg      <= SP_RESET;
         wdata_reg     <= '0;
      end else begin
         state_reg     <= state_next;
         cnt_reg       <= cnt_next;
         gie_reg       <= gie_next;
         flag_reg      <= flag_next;
         ack_reg       <= ack_next;
         sel_reg       <= sel_next;
         ret_pc_reg    <= ret_pc_next;
         pop_hi_reg    <= pop_hi_next;
         sp_reg        <= sp_next;
         boot_reg      <= boot_next;
         stall_reg     <= stall_next;
         wake_reg      <= wake_next;
         load_reg      <= load_next;
         load_addr_reg <= load_addr_next;
         we_reg        <= we_next;
         re_reg        <= re_next;
         addr_reg      <= addr_next;
         wdata_reg     <= wdata_next;
      end
   end

   assign gie_o          = gie_reg;
   assign flags_o        = flag_reg;
   assign ack_o          = ack_reg;
   assign core_stall_o   = stall_reg;
   assign wake_o         = wake_reg;
   assign pc_load_o      = load_reg;
   assign pc_load_addr_o = load_addr_reg;
   assign stack_we_o     = we_reg;
   assign stack_re_o     = re_reg;
   assign stack_addr_o   = addr_reg;
   assign stack_wdata_o  = wdata_reg;
   assign sp_o           = sp_reg;

   default clocking cis_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence entry_start_s;
      (state_reg == CIS_IDLE || state_reg == CIS_WAKE) && state_next == CIS_ENTRY;
   endsequence
   sequence entry_body_s;
      (state_reg == CIS_ENTRY && core_stall_o)[*4];
   endsequence
   sequence ret_start_s;
      state_reg == CIS_IDLE && state_next == CIS_RETURN;
   endsequence
   sequence ret_body_s;
      (state_reg == CIS_RETURN)[*4];
   endsequence

   gie_clear_a: assert property (do_take |=> !gie_reg)
      else $error("global enable not cleared on accept");
   cli_block_a: assert property (cli_i |-> !do_take)
      else $error("interrupt taken with global disable");
   entry_len_a: assert property (entry_start_s |=> entry_body_s ##1
                                 (state_reg == CIS_JUMP && pc_load_o))
      else $error("entry sequence length wrong");
   push_sp_a: assert property (entry_start_s |-> ##3 (sp_reg == $past(sp_reg, 2) - SP_STEP))
      else $error("stack pointer not lowered by two");
   return_len_a: assert property (ret_start_s |=> ret_body_s ##1
                                  (gie_reg && pc_load_o && state_reg == CIS_IDLE))
      else $error("return sequence wrong");
   jump_len_a: assert property ($rose(state_reg == CIS_JUMP) |->
                                (state_reg == CIS_JUMP)[*3] ##1 state_reg == CIS_IDLE)
      else $error("jump window length wrong");
   enable_gate_a: assert property ((|ack_o) |-> $past(gie_reg) &&
                                   (($past(irq_enable_i) & ack_o) == ack_o))
      else $error("ack without enables");
   prio_pick_a: assert property ((|ack_o) |->
                                 ((($past(eligible) & (ack_o - 1'b1)) == '0)))
      else $error("lower priority source served first");
   hw_clear_a: assert property ((|(ack_o & ~LEVEL_MASK)) |->
                                ((flag_reg & ack_o & ~$past(flag_event_i)) == '0))
      else $error("flag not cleared on vectoring");
   set_wins_a: assert property ((|(flag_event_i & ~LEVEL_MASK)) |=>
                                ((flag_reg & $past(flag_event_i & ~LEVEL_MASK)) ==
                                 $past(flag_event_i & ~LEVEL_MASK)))
      else $error("flag event lost");
   level_only_a: assert property ((|(ack_o & LEVEL_MASK)) |->
                                  ((($past(level_req_i) & ack_o & LEVEL_MASK)) ==
                                   (ack_o & LEVEL_MASK)))
      else $error("level source served without condition");
   wake_len_a: assert property ($rose(state_reg == CIS_WAKE) |->
                                (state_reg == CIS_WAKE)[*4])
      else $error("wake stretch too short");
endmodule : cis_sequencer
`default_nettype wire

// ===== verification/cis_stack_model.sv
/*
 cis_stack_model: byte-wide stack memory standing behind the sequencer.
 assumes one clock; read data is valid the cycle after a read strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module cis_stack_model
   import cis_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              we_i,
   input  wire logic              re_i,
   input  wire logic [SP_W-1:0]   addr_i,
   input  wire logic [BYTE_W-1:0] wdata_i,
   output var  logic [BYTE_W-1:0] rdata_o = 8'h00
);
   logic [BYTE_W-1:0] mem [0:(2**SP_W)-1];
   // outside a read cycle the bus flips, so a stale byte never looks valid
   always @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
      rdata_o <= re_i ? mem[addr_i] : ~rdata_o;
   end
endmodule : cis_stack_model
`default_nettype wire

// ===== verification/test_cpu_interrupt_sequencer.sv
/*
 test_cpu_interrupt_sequencer: directed scenarios for cis_sequencer.
 assumes cis_pkg and cis_stack_model; inputs change on the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module test_cpu_interrupt_sequencer;
   import cis_pkg::*;
   // short sleep start-up keeps the wake scenario brief
   localparam int SLP = 2;
   logic              sys_clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              done = 1'b0, cli = 1'b0, sei = 1'b0, return_from_irq = 1'b0, sleep = 1'b0;
   logic              gwr = 1'b0, gdat = 1'b0, clr_wr = 1'b0, sp_wr = 1'b0;
   logic              vrel = 1'b0, fuse = 1'b0, lock_app = 1'b0, lock_boot = 1'b0;
   logic [7:0]        ev = 8'h00, en = 8'h00, clr = 8'h00, lvl = 8'h00;
   logic [PC_W-1:0]   pc = 15'h0000;
   logic [SP_W-1:0]   sp_dat = 16'h0000, sp_exp = 16'h0000;
   logic              gie_o, core_stall_o, wake_o, pc_load_o, stack_we_o, stack_re_o;
   logic [7:0]        flags_o, ack_o, stack_wdata_o, rdata;
   logic [PC_W-1:0]   pc_load_addr_o;
   logic [SP_W-1:0]   stack_addr_o, sp_o;
   int                err_total = 0;
   int                tests_run = 0;

   always #20 sys_clk_i = ~sys_clk_i;

   // source 7 is level type so the level path is exercised
   cis_sequencer #(.LEVEL_MASK(8'h80), .SLEEP_STARTUP_CYC(SLP)) uut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_done_i(done), .cli_i(cli), .sei_i(sei),
      .return_from_irq_i(return_from_irq), .sleeping_i(sleep), .status_gie_wr_i(gwr), .status_gie_data_i(gdat),
      .flag_event_i(ev), .level_req_i(lvl), .irq_enable_i(en), .flag_clear_wr_i(clr_wr),
      .flag_clear_data_i(clr), .vector_relocate_i(vrel), .reset_vector_relocate_fuse_i(fuse),
      .app_boot_lock_bit_i(lock_app), .boot_section_lock_bit_i(lock_boot), .pc_i(pc),
      .sp_wr_i(sp_wr), .sp_wr_data_i(sp_dat), .stack_rdata_i(rdata), .gie_o(gie_o),
      .flags_o(flags_o), .ack_o(ack_o), .core_stall_o(core_stall_o), .wake_o(wake_o),
      .pc_load_o(pc_load_o), .pc_load_addr_o(pc_load_addr_o), .stack_we_o(stack_we_o),
      .stack_re_o(stack_re_o), .stack_addr_o(stack_addr_o), .stack_wdata_o(stack_wdata_o),
      .sp_o(sp_o));

   cis_stack_model stack (
      .clk_i(sys_clk_i), .we_i(stack_we_o), .re_i(stack_re_o), .addr_i(stack_addr_o),
      .wdata_i(stack_wdata_o), .rdata_o(rdata));

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n = 1);
      repeat (n) @(negedge sys_clk_i);
   endtask : cyc

   task automatic tally_and_finish();
      $display("tests_run=%0d err_total=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic do_reset(input logic f);
      int k;
      rst_i = 1'b1;
      fuse = f;
      cyc(16);
      rst_i = 1'b0;
      cyc();
      for (k = 0; k < 3 && pc_load_o !== 1'b1; k++) cyc();
      chk(pc_load_addr_o, f ? BOOT_START_DEF : APP_BASE);
      chk({gie_o, sp_o}, {1'b0, SP_RESET});
      sp_exp = 16'h0400;
      sp_wr = 1'b1;
      sp_dat = sp_exp;
      cyc();
      sp_wr = 1'b0;
   endtask : do_reset

   task automatic set_gie(input logic v);
      gwr = 1'b1;
      gdat = v;
      cyc();
      gwr = 1'b0;
   endtask : set_gie

   task automatic fire(input logic [7:0] m);
      ev = m;
      cyc();
      ev = 8'h00;
   endtask : fire

   task automatic boundary(input logic [PC_W-1:0] p, input logic c, input logic s);
      done = 1'b1;
      pc = p;
      cli = c;
      sei = s;
      cyc();
      done = 1'b0;
      cli = 1'b0;
      sei = 1'b0;
   endtask : boundary

   task automatic entry(input int idx, input logic [PC_W-1:0] p, input logic [PC_W-1:0] b);
      boundary(p, 1'b0, 1'b0);
      chk(ack_o, 8'h01 << idx);
      chk({core_stall_o, gie_o, flags_o[idx]}, 3'b100);
      cyc();
      chk({stack_we_o, stack_addr_o, stack_wdata_o}, {1'b1, sp_exp, p[7:0]});
      cyc();
      chk({stack_we_o, stack_addr_o, stack_wdata_o}, {1'b1, sp_exp - SP_ONE, 1'b0, p[14:8]});
      sp_exp = sp_exp - SP_STEP;
      chk(sp_o, sp_exp);
      cyc();
      chk(core_stall_o, 1'b1);
      cyc();
      chk({pc_load_o, core_stall_o}, 2'b10);
      chk(pc_load_addr_o, b + 15'((idx + 1) * VEC_STRIDE));
      cyc(3);
   endtask : entry

   task automatic ret(input logic [PC_W-1:0] p);
      return_from_irq = 1'b1;
      cyc();
      return_from_irq = 1'b0;
      chk(core_stall_o, 1'b1);
      cyc();
      chk({stack_re_o, stack_addr_o}, {1'b1, sp_exp + SP_ONE});
      cyc();
      sp_exp = sp_exp + SP_STEP;
      chk({stack_re_o, stack_addr_o, sp_o}, {1'b1, sp_exp, sp_exp});
      cyc(2);
      chk({pc_load_o, gie_o, core_stall_o, pc_load_addr_o}, {3'b110, p});
   endtask : ret

   task automatic t_nest();
      fire(8'h28);
      boundary(15'h0100, 1'b0, 1'b0);
      chk({ack_o, flags_o}, 16'h0028);
      en = 8'hff;
      set_gie(1'b1);
      entry(3, 15'h0101, APP_BASE);
      set_gie(1'b1);
      entry(5, 15'h0050, APP_BASE);
      fire(8'h40);
      ret(15'h0050);
      cyc(2);
      chk(ack_o, 8'h00);
      entry(6, 15'h0051, APP_BASE);
      ret(15'h0051);
      ret(15'h0101);
   endtask : t_nest

   task automatic t_gate();
      set_gie(1'b0);
      fire(8'h06);
      boundary(15'h0200, 1'b0, 1'b1);
      chk({ack_o, gie_o}, {8'h00, 1'b1});
      entry(1, 15'h0201, APP_BASE);
      set_gie(1'b1);
      boundary(15'h0030, 1'b1, 1'b0);
      chk({ack_o, gie_o, flags_o}, {8'h00, 1'b0, 8'h04});
      clr_wr = 1'b1;
      cyc();
      chk(flags_o, 8'h04);
      clr = 8'h04;
      cyc();
      clr_wr = 1'b0;
      chk(flags_o, 8'h00);
      ret(15'h0201);
   endtask : t_gate

   task automatic t_reloc();
      vrel = 1'b1;
      lock_app = 1'b1;
      fire(8'h01);
      boundary(15'h0300, 1'b0, 1'b0);
      chk(ack_o, 8'h00);
      lock_app = 1'b0;
      entry(0, 15'h0301, BOOT_START_DEF);
      ret(15'h0301);
      // boot lock: vectors in the application area, code running in the boot area
      vrel = 1'b0;
      lock_boot = 1'b1;
      fire(8'h01);
      boundary(15'h7100, 1'b0, 1'b0);
      chk(ack_o, 8'h00);
      lock_boot = 1'b0;
      entry(0, 15'h7101, APP_BASE);
      ret(15'h7101);
   endtask : t_reloc

   task automatic t_level();
      en = 8'h7f;
      lvl = 8'h80;
      boundary(15'h0500, 1'b0, 1'b0);
      chk(ack_o, 8'h00);
      // condition gone before the enable arrives: nothing may be taken
      lvl = 8'h00;
      en = 8'hff;
      boundary(15'h0501, 1'b0, 1'b0);
      chk({ack_o, flags_o}, 16'h0000);
      fire(8'h80);
      chk(flags_o, 8'h00);
      lvl = 8'h80;
      entry(7, 15'h0502, APP_BASE);
      lvl = 8'h00;
      ret(15'h0502);
   endtask : t_level

   task automatic t_sleep();
      int n;
      sleep = 1'b1;
      pc = 15'h0400;
      fire(8'h10);
      for (n = 0; n < 4 && wake_o !== 1'b1; n++) cyc();
      chk(wake_o, 1'b1);
      for (n = 0; n < 20 && ack_o !== 8'h10; n++) cyc();
      sleep = 1'b0;
      chk(n inside {SLP + WAKE_EXTRA_CYC, SLP + WAKE_EXTRA_CYC + 1}, 1'b1);
      sp_exp = sp_exp - SP_STEP;
      cyc(7);
      ret(15'h0400);
   endtask : t_sleep

   initial begin
      do_reset(1'b1);
      t_nest();
      // second reset in mid-run, with global enable set and no flags pending
      do_reset(1'b0);
      t_gate();
      t_reloc();
      t_sleep();
      t_level();
      tally_and_finish();
   end

   // whole run is under two hundred cycles; this span leaves ample margin
   initial begin
      cyc(3000);
      err_total++;
      tally_and_finish();
   end
endmodule : test_cpu_interrupt_sequencer
`default_nettype wire
